/* File: bench/host_model.sv */
// Host processor model on the serial register port
`timescale 1ns/1ps
`default_nettype none
module host_model (
    input wire logic clk,
    output logic cs_n,
    output logic sclk,
    output logic sdi,
    input wire logic sdo,
    input wire logic sdo_oe
);
    initial begin
        cs_n = 1'b1;
        sclk = 1'b0;
        sdi = 1'b0;
    end
    // One frame: read flag, address, data, MSB first
    task automatic xfer(input logic rd, input logic [6:0] a, input logic [7:0] wd, output logic [7:0] q);
        logic [15:0] f;
        f = {rd, a, wd};
        q = 8'h00;
        @(posedge clk) #1 cs_n = 1'b0;
        for (int i = 15; i >= 0; i--) begin
            sdi = f[i];
            repeat (6) @(posedge clk);
            #1 sclk = 1'b1;
            // On a read a released data line reads inverted; a write must leave it released
            if (i < 8) q[i] = (sdo_oe == rd) ? (rd & sdo) : ~(rd & sdo);
            repeat (6) @(posedge clk);
            #1 sclk = 1'b0;
        end
        repeat (6) @(posedge clk);
        #1 cs_n = 1'b1;
        repeat (6) @(posedge clk);
        #1;
    endtask
endmodule // host_model
`default_nettype wire

/* File: bench/testbench.sv */
// Self-checking bench for the receive control and pattern test block
`timescale 1ns/1ps
`default_nettype none
module testbench import liu_pkg::*;;
    logic clk, rst, host_mode, cs_n, sclk, sdi, sdo, sdo_oe;
    logic [23:0] h;
    logic [2:0] tx_clk, tx_p, tx_n, rx_clk, rx_p, rx_n, lcv, los;
    logic [2:0] tx_ready, tx_po, tx_no, rx_po, rx_no, eq, mon, aloop;
    int bad_count = 0;
    int tests_run = 0;
    int e, o, hn, pm, lm;
    logic [7:0] r;
    liu_rx_control_and_prbs_test liu_rx_control_and_prbs_test_i (.SYS_CLK(clk), .SYS_RST(rst),
        .HOST_MODE(host_mode), .SPI_CS_N(cs_n), .SPI_SCLK(sclk), .SPI_SDI(sdi), .SPI_SDO(sdo),
        .SPI_SDO_OE(sdo_oe), .TX_CLK(tx_clk), .TX_POSITIVE_DATA_IN(tx_p), .TX_NEGATIVE_DATA_IN(tx_n),
        .RX_CLK(rx_clk), .RX_POS_IN(rx_p), .RX_NEG_IN(rx_n), .LINE_CODE_VIOLATION_IN(lcv),
        .RX_LOS_IN(los), .TX_READY(tx_ready), .TX_POS_OUT(tx_po), .TX_NEG_OUT(tx_no),
        .RX_POSITIVE_DATA_OUT(rx_po), .RX_NEGATIVE_DATA_OUT(rx_no), .EQ_ENABLE(eq),
        .MONITOR_MODE(mon), .ANALOG_LOOP(aloop));
    host_model host_model_i (.clk(clk), .cs_n(cs_n), .sclk(sclk), .sdi(sdi), .sdo(sdo), .sdo_oe(sdo_oe));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic print_verdict();
        $display("Comparisons %0d, mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic check(input string n, input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", n, exp, seen);
        end
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        host_model_i.xfer(1'b0, a, d, r);
        check("write drive", r, 8'h00);
    endtask
    task automatic rd(input logic [6:0] a, input logic [7:0] exp);
        host_model_i.xfer(1'b1, a, 8'h00, r);
        check("register", r, exp);
    endtask
    // One bit time on channel 0 transmit and receive clocks
    task automatic step(input logic p);
        @(posedge clk) #1 rx_p[0] = p;
        tx_clk[0] = 1'b1;
        rx_clk[0] = 1'b1;
        repeat (5) @(posedge clk);
        #1 tx_clk[0] = 1'b0;
        rx_clk[0] = 1'b0;
        repeat (5) @(posedge clk);
        #1;
    endtask
    // Loop line output back to receive input, counting error flags
    task automatic run(input int n, input int inj);
        e = 0;
        o = 0;
        for (int i = 0; i < n; i++) begin
            step(tx_po[0] ^ (i == inj));
            e += int'(rx_no[0] === 1'b1);
            o += int'(tx_po[0] === 1'b1);
            // Line bit against the two earlier bits the polynomial names
            h = {h[22:0], tx_po[0]};
            hn++;
            if (hn > 23 && (tx_po[0] !== (lm ? h[23] ^ h[18] : h[15] ^ h[14]))) pm++;
        end
    endtask
    initial begin
        repeat (50000) @(posedge clk);
        bad_count++;
        print_verdict();
    end
    initial begin
        {rst, host_mode} = 2'b11;
        {tx_clk, tx_p, tx_n, rx_clk, rx_p, rx_n, lcv, los} = '0;
        repeat (16) @(posedge clk);
        #1 rst = 1'b0;
        repeat (4) @(posedge clk);
        for (int c = 0; c < 3; c++) begin
            rd(7'(RX_CTRL_BASE + CH_STRIDE * c), 8'h00);
            rd(7'(CH_CTRL_BASE + CH_STRIDE * c), 8'h00);
            wr(7'(RX_CTRL_BASE + CH_STRIDE * c), 8'h01);
        end
        check("eq", 8'(eq), 8'h07);
        check("monitor", 8'(mon), 8'h00);
        wr(7'h07, 8'hff);
        rd(7'h07, 8'h00);
        wr(CH_CTRL_BASE, 8'hff);
        rd(CH_CTRL_BASE, 8'h3f);
        wr(7'(RX_CTRL_BASE + CH_STRIDE), 8'h02);
        check("eq off", 8'(eq), 8'h05);
        check("monitor on", 8'(mon), 8'h02);
        wr(CH_CTRL_BASE, 8'h00);
        wr(RX_CTRL_BASE, 8'h04);
        {los[0], rx_n[0]} = 2'b11;
        step(1'b1);
        check("muted", 8'({rx_po[0], rx_no[0]}), 8'h00);
        los[0] = 1'b0;
        step(1'b1);
        check("unmuted", 8'({rx_po[0], rx_no[0]}), 8'h03);
        wr(RX_CTRL_BASE, 8'h00);
        los[0] = 1'b1;
        step(1'b1);
        check("no mute", 8'({rx_po[0], rx_no[0]}), 8'h03);
        {los[0], rx_n[0], lcv[0]} = 3'b001;
        wr(CH_CTRL_BASE, 8'h01);
        step(1'b1);
        check("violation", 8'(rx_no[0]), 8'h01);
        lcv[0] = 1'b0;
        for (int k = 0; k < 4; k++) begin
            wr(CH_CTRL_BASE, 8'(k * 8));
            check("analog loop", 8'(aloop[0]), 8'(k == 1));
        end
        tx_p[0] = 1'b1;
        step(1'b0);
        check("digital loop", 8'(rx_po[0]), 8'h01);
        tx_n[0] = 1'b1;
        wr(CH_CTRL_BASE, 8'h10);
        run(20, -1);
        check("remote fill", 8'(tx_ready[0]), 8'h00);
        wr(CH_CTRL_BASE, 8'h00);
        run(20, -1);
        check("drained", 8'({tx_ready[0], tx_po[0], tx_no[0]}), 8'h07);
        for (int m = 0; m < 2; m++) begin
            wr(CH_CTRL_BASE, m ? 8'h24 : 8'h20);
            lm = m;
            hn = 0;
            pm = 0;
            run(40, -1);
            run(60, -1);
            check("clean errors", 8'(e), 8'h00);
            check("pattern law", 8'(pm), 8'h00);
            check("pattern mix", 8'(o > 0 && o < 60 && tx_no[0] === 1'b0), 8'h01);
            run(40, 5);
            check("error count", 8'(e), 8'h03);
        end
        wr(CH_CTRL_BASE, 8'h00);
        run(20, -1);
        check("pattern off", 8'({tx_po[0], tx_no[0], rx_no[0]}), 8'h06);
        host_mode = 1'b0;
        wr(CH_CTRL_BASE, 8'h20);
        run(20, -1);
        check("pin control", 8'({tx_po[0], tx_no[0]}), 8'h03);
        print_verdict();
    end
endmodule // testbench
`default_nettype wire

/* File: core/liu_fifo.sv */
// Parameterised first-in first-out buffer with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none
module liu_fifo #(
    parameter int WIDTH = 2,
    parameter int DEPTH = 16
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic in_valid,
    input wire logic [WIDTH-1:0] in_data,
    output logic in_ready,
    output logic out_valid,
    output logic [WIDTH-1:0] out_data,
    input wire logic out_ready
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wr_ptr;
    logic [AW:0] rd_ptr;

    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
        $error("FIFO depth must be a power of two");
    end

    assign in_ready = !((wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]));
    assign out_valid = wr_ptr != rd_ptr;
    assign out_data = mem[rd_ptr[AW-1:0]];

    always_ff @(posedge clk) begin
        if (in_valid && in_ready) begin
            mem[wr_ptr[AW-1:0]] <= in_data;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            wr_ptr <= '0;
        end else if (in_valid && in_ready) begin
            wr_ptr <= wr_ptr + 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            rd_ptr <= '0;
        end else if (out_valid && out_ready) begin
            rd_ptr <= rd_ptr + 1'b1;
        end
    end
endmodule // liu_fifo
`default_nettype wire

/* File: core/liu_pkg.sv */
// Constants and types shared by the line interface control block
package liu_pkg;
    localparam int CH_COUNT = 3;
    localparam int TX_FIFO_DEPTH = 16;
    localparam int TX_FIFO_WIDTH = 2;
    localparam int ADDR_BITS = 7;
    localparam int DATA_BITS = 8;
    localparam int RW_BITS = 6;
    localparam logic [6:0] RX_CTRL_BASE = 7'h05;
    localparam logic [6:0] CH_CTRL_BASE = 7'h06;
    localparam logic [6:0] CH_STRIDE = 7'h08;
    localparam logic [5:0] REG_RESET = 6'h00;
    localparam int RXC_EQ = 0;
    localparam int RXC_MON = 1;
    localparam int RXC_MUTE = 2;
    localparam int CHC_SR = 0;
    localparam int CHC_STS = 1;
    localparam int CHC_E3 = 2;
    localparam int CHC_LLB = 3;
    localparam int CHC_RLB = 4;
    localparam int CHC_PRBS = 5;
    localparam int PRBS_SHORT_LEN = 15;
    localparam int PRBS_LONG_LEN = 23;
    localparam int SHORT_FB_A = 14;
    localparam int SHORT_FB_B = 13;
    localparam int LONG_FB_A = 22;
    localparam int LONG_FB_B = 17;
    localparam logic [2:0] ADDR_LAST = 3'h6;
    localparam logic [2:0] DATA_LAST = 3'h7;
    typedef enum logic [1:0] {
        SER_IDLE = 2'b00,
        SER_ADDR = 2'b01,
        SER_DATA = 2'b11,
        SER_DONE = 2'b10
    } ser_state_t;
endpackage

/* File: core/liu_prbs.sv */
// Pseudo-random pattern generator and self-synchronising checker for one channel
`timescale 1ns/1ps
`default_nettype none
module liu_prbs import liu_pkg::*; (
    input wire logic clk,
    input wire logic rst,
    input wire logic enable,
    input wire logic long_mode,
    input wire logic gen_step,
    input wire logic chk_step,
    input wire logic chk_bit,
    output logic gen_bit,
    output logic err
);
    logic [PRBS_LONG_LEN-1:0] gen_reg;
    logic [PRBS_LONG_LEN-1:0] chk_reg;
    logic [4:0] fill;
    logic [4:0] fill_need;
    logic predicted;

    function automatic logic feedback(input logic [PRBS_LONG_LEN-1:0] r, input logic lm);
        return lm ? (r[LONG_FB_A] ^ r[LONG_FB_B]) : (r[SHORT_FB_A] ^ r[SHORT_FB_B]);
    endfunction

    assign fill_need = long_mode ? 5'(PRBS_LONG_LEN) : 5'(PRBS_SHORT_LEN);
    assign gen_bit = feedback(gen_reg, long_mode);
    assign predicted = feedback(chk_reg, long_mode);

    always_ff @(posedge clk) begin
        if (rst || !enable) begin
            gen_reg <= '1;
        end else if (gen_step) begin
            gen_reg <= {gen_reg[PRBS_LONG_LEN-2:0], gen_bit};
        end
    end

    always_ff @(posedge clk) begin
        if (rst || !enable) begin
            chk_reg <= '0;
            fill <= '0;
            err <= 1'b0;
        end else if (chk_step) begin
            chk_reg <= {chk_reg[PRBS_LONG_LEN-2:0], chk_bit};
            err <= (fill >= fill_need) && (chk_bit ^ predicted);
            if (fill < fill_need) begin
                fill <= fill + 5'd1;
            end
        end
    end

    AST_PRBS_NOT_STUCK: assert property (@(posedge clk) disable iff (rst)
        enable |-> gen_reg != '0)
        else $error("pattern generator register locked at zero");
    AST_PRBS_FILL_QUIET: assert property (@(posedge clk) disable iff (rst)
        enable && chk_step && fill < fill_need |=> !err)
        else $error("checker flagged an error before it was filled");
endmodule // liu_prbs
`default_nettype wire

/* File: core/liu_rx_control_and_prbs_test.sv */
// Three-channel receive control, channel control and pattern test with serial host port
`timescale 1ns/1ps
`default_nettype none
module liu_rx_control_and_prbs_test import liu_pkg::*; #(
    parameter int NUM_CH = CH_COUNT,
    parameter int FIFO_DEPTH = TX_FIFO_DEPTH
) (
    input wire logic SYS_CLK,
    input wire logic SYS_RST,
    input wire logic HOST_MODE,
    input wire logic SPI_CS_N,
    input wire logic SPI_SCLK,
    input wire logic SPI_SDI,
    output logic SPI_SDO,
    output logic SPI_SDO_OE,
    input wire logic [NUM_CH-1:0] TX_CLK,
    input wire logic [NUM_CH-1:0] TX_POSITIVE_DATA_IN,
    input wire logic [NUM_CH-1:0] TX_NEGATIVE_DATA_IN,
    input wire logic [NUM_CH-1:0] RX_CLK,
    input wire logic [NUM_CH-1:0] RX_POS_IN,
    input wire logic [NUM_CH-1:0] RX_NEG_IN,
    input wire logic [NUM_CH-1:0] LINE_CODE_VIOLATION_IN,
    input wire logic [NUM_CH-1:0] RX_LOS_IN,
    output logic [NUM_CH-1:0] TX_READY,
    output logic [NUM_CH-1:0] TX_POS_OUT,
    output logic [NUM_CH-1:0] TX_NEG_OUT,
    output logic [NUM_CH-1:0] RX_POSITIVE_DATA_OUT,
    output logic [NUM_CH-1:0] RX_NEGATIVE_DATA_OUT,
    output logic [NUM_CH-1:0] EQ_ENABLE,
    output logic [NUM_CH-1:0] MONITOR_MODE,
    output logic [NUM_CH-1:0] ANALOG_LOOP
);
    localparam int PW = 4 + 8 * NUM_CH;

    logic [PW-1:0] pin_meta;
    logic [PW-1:0] pin_sync;
    logic host_s;
    logic cs_n_s;
    logic sclk_s;
    logic sdi_s;
    logic sclk_q;
    logic sclk_rise;
    logic [NUM_CH-1:0] txc_s;
    logic [NUM_CH-1:0] tpos_s;
    logic [NUM_CH-1:0] tneg_s;
    logic [NUM_CH-1:0] rxc_s;
    logic [NUM_CH-1:0] rpos_s;
    logic [NUM_CH-1:0] rneg_s;
    logic [NUM_CH-1:0] lcv_s;
    logic [NUM_CH-1:0] los_s;
    logic [NUM_CH-1:0] txc_q;
    logic [NUM_CH-1:0] rxc_q;
    logic [NUM_CH-1:0] tx_edge;
    logic [NUM_CH-1:0] rx_edge;
    logic [NUM_CH-1:0] prbs_en;
    logic [NUM_CH-1:0] prbs_err;
    logic [NUM_CH-1:0] gen_bit;
    logic [NUM_CH-1:0] remote;
    logic [NUM_CH-1:0] dig_loop;
    logic [NUM_CH-1:0] mute;
    logic [NUM_CH-1:0] src_pos;
    logic [NUM_CH-1:0] src_neg;
    logic [NUM_CH-1:0] fifo_in_ready;
    logic [NUM_CH-1:0] fifo_valid;
    logic [TX_FIFO_WIDTH-1:0] fifo_data [NUM_CH];
    logic [RW_BITS-1:0] rx_ctrl [NUM_CH];
    logic [RW_BITS-1:0] ch_ctrl [NUM_CH];
    ser_state_t state;
    logic [2:0] cnt;
    logic rw;
    logic [ADDR_BITS-1:0] addr;
    logic [DATA_BITS-1:0] shift;
    logic [DATA_BITS-1:0] rd_shift;
    logic [DATA_BITS-1:0] rd_value;
    logic [ADDR_BITS-1:0] rd_addr;
    logic [3:0] rd_dec;
    logic [3:0] wr_dec;
    logic wr_en;
    logic [DATA_BITS-1:0] wr_data;

    default clocking cb @(posedge SYS_CLK);
    endclocking
    default disable iff (SYS_RST);

    if (NUM_CH < 1 || NUM_CH > 4) begin : g_bad_ch
        $error("channel count must be 1 to 4");
    end

    // Address decode: {receive hit, channel hit, channel index}
    function automatic logic [3:0] decode(input logic [ADDR_BITS-1:0] a);
        logic in_range;
        in_range = (a[6:5] == 2'b00) && ({1'b0, a[4:3]} < 3'(NUM_CH));
        return {in_range && (a[2:0] == RX_CTRL_BASE[2:0]),
                in_range && (a[2:0] == CH_CTRL_BASE[2:0]), a[4:3]};
    endfunction

    // Pin synchroniser
    always_ff @(posedge SYS_CLK) begin
        if (SYS_RST) begin
            pin_meta <= '0;
            pin_sync <= '0;
        end else begin
            pin_meta <= {HOST_MODE, SPI_CS_N, SPI_SCLK, SPI_SDI, TX_CLK, TX_POSITIVE_DATA_IN,
                         TX_NEGATIVE_DATA_IN, RX_CLK, RX_POS_IN, RX_NEG_IN,
                         LINE_CODE_VIOLATION_IN, RX_LOS_IN};
            pin_sync <= pin_meta;
        end
    end

    assign {host_s, cs_n_s, sclk_s, sdi_s, txc_s, tpos_s, tneg_s, rxc_s, rpos_s, rneg_s,
            lcv_s, los_s} = pin_sync;

    // Edge detection
    always_ff @(posedge SYS_CLK) begin
        if (SYS_RST) begin
            sclk_q <= 1'b0;
            txc_q <= '0;
            rxc_q <= '0;
        end else begin
            sclk_q <= sclk_s;
            txc_q <= txc_s;
            rxc_q <= rxc_s;
        end
    end

    assign sclk_rise = sclk_s & ~sclk_q;
    assign tx_edge = txc_s & ~txc_q;
    assign rx_edge = rxc_s & ~rxc_q;

    // Serial port frame: read flag, seven address bits, eight data bits
    always_ff @(posedge SYS_CLK) begin
        if (SYS_RST) begin
            state <= SER_IDLE;
            cnt <= '0;
            rw <= 1'b0;
            addr <= '0;
            shift <= '0;
        end else if (cs_n_s) begin
            state <= SER_IDLE;
            cnt <= '0;
        end else if (sclk_rise) begin
            unique case (state)
                SER_IDLE: begin
                    rw <= sdi_s;
                    cnt <= '0;
                    state <= SER_ADDR;
                end
                SER_ADDR: begin
                    addr <= {addr[5:0], sdi_s};
                    cnt <= cnt + 3'd1;
                    if (cnt == ADDR_LAST) begin
                        cnt <= '0;
                        state <= SER_DATA;
                    end
                end
                SER_DATA: begin
                    shift <= {shift[6:0], sdi_s};
                    cnt <= cnt + 3'd1;
                    if (cnt == DATA_LAST) begin
                        state <= SER_DONE;
                    end
                end
                SER_DONE: begin
                    state <= SER_DONE;
                end
            endcase
        end
    end

    assign rd_addr = {addr[5:0], sdi_s};
    assign rd_dec = decode(rd_addr);
    assign wr_dec = decode(addr);
    assign wr_data = {shift[6:0], sdi_s};
    assign wr_en = !cs_n_s && sclk_rise && state == SER_DATA && cnt == DATA_LAST && !rw;

    always_comb begin
        rd_value = 8'h00;
        if (rd_dec[3]) begin
            rd_value = {2'b00, rx_ctrl[rd_dec[1:0]]};
        end else if (rd_dec[2]) begin
            rd_value = {2'b00, ch_ctrl[rd_dec[1:0]]};
        end
    end

    // Read data shifted out most significant bit first
    always_ff @(posedge SYS_CLK) begin
        if (SYS_RST) begin
            SPI_SDO <= 1'b0;
            SPI_SDO_OE <= 1'b0;
            rd_shift <= '0;
        end else if (cs_n_s) begin
            SPI_SDO <= 1'b0;
            SPI_SDO_OE <= 1'b0;
        end else if (sclk_rise) begin
            if (state == SER_ADDR && cnt == ADDR_LAST && rw) begin
                SPI_SDO <= rd_value[7];
                rd_shift <= {rd_value[6:0], 1'b0};
                SPI_SDO_OE <= 1'b1;
            end else if (state == SER_DATA && SPI_SDO_OE) begin
                SPI_SDO <= rd_shift[7];
                rd_shift <= {rd_shift[6:0], 1'b0};
                if (cnt == DATA_LAST) begin
                    SPI_SDO_OE <= 1'b0;
                end
            end
        end
    end

    always_ff @(posedge SYS_CLK) begin
        for (int i = 0; i < NUM_CH; i++) begin
            if (SYS_RST) begin
                rx_ctrl[i] <= REG_RESET;
                ch_ctrl[i] <= REG_RESET;
            end else if (wr_en && wr_dec[1:0] == 2'(i)) begin
                if (wr_dec[3]) begin
                    rx_ctrl[i] <= wr_data[RW_BITS-1:0];
                end
                if (wr_dec[2]) begin
                    ch_ctrl[i] <= wr_data[RW_BITS-1:0];
                end
            end
        end
    end

    for (genvar g = 0; g < NUM_CH; g++) begin : g_ch
        assign remote[g] = ch_ctrl[g][CHC_RLB] & ~ch_ctrl[g][CHC_LLB];
        assign dig_loop[g] = ch_ctrl[g][CHC_RLB] & ch_ctrl[g][CHC_LLB];
        assign prbs_en[g] = ch_ctrl[g][CHC_PRBS] & host_s;
        assign mute[g] = rx_ctrl[g][RXC_MUTE] & los_s[g];
        assign src_pos[g] = dig_loop[g] ? tpos_s[g] : rpos_s[g];
        assign src_neg[g] = dig_loop[g] ? tneg_s[g] : rneg_s[g];

        liu_fifo #(
            .WIDTH(TX_FIFO_WIDTH),
            .DEPTH(FIFO_DEPTH)
        ) u_fifo (
            .clk(SYS_CLK),
            .rst(SYS_RST),
            .in_valid(tx_edge[g] & ~prbs_en[g]),
            .in_data({tpos_s[g], tneg_s[g]}),
            .in_ready(fifo_in_ready[g]),
            .out_valid(fifo_valid[g]),
            .out_data(fifo_data[g]),
            .out_ready(tx_edge[g] & ~remote[g])
        );

        liu_prbs u_prbs (
            .clk(SYS_CLK),
            .rst(SYS_RST),
            .enable(prbs_en[g]),
            .long_mode(ch_ctrl[g][CHC_E3]),
            .gen_step(tx_edge[g]),
            .chk_step(rx_edge[g]),
            .chk_bit(src_pos[g]),
            .gen_bit(gen_bit[g]),
            .err(prbs_err[g])
        );

        AST_MUTE_LOW: assert property (
            rx_edge[g] && mute[g] |=> !RX_POSITIVE_DATA_OUT[g] && !RX_NEGATIVE_DATA_OUT[g])
            else $error("recovered data not muted during loss");
        AST_PASS_DATA: assert property (
            rx_edge[g] && !rx_ctrl[g][RXC_MUTE] |=> RX_POSITIVE_DATA_OUT[g] == $past(src_pos[g]))
            else $error("recovered data not passed");
        AST_MONITOR_FOLLOW: assert property (
            wr_en && wr_dec[3] && wr_dec[1:0] == 2'(g) |-> ##2 MONITOR_MODE[g] == $past(wr_data[RXC_MON], 2))
            else $error("monitor mode output does not follow write");
        AST_EQ_FOLLOW: assert property (
            wr_en && wr_dec[3] && wr_dec[1:0] == 2'(g) |-> ##2 EQ_ENABLE[g] == $past(wr_data[RXC_EQ], 2))
            else $error("equalizer enable does not follow write");
        AST_GEN_REPLACES: assert property (
            tx_edge[g] && prbs_en[g] && !remote[g] |=> TX_POS_OUT[g] == $past(gen_bit[g]) && !TX_NEG_OUT[g])
            else $error("transmit data not replaced by pattern");
        AST_OFF_QUIET: assert property (
            !prbs_en[g] |=> !prbs_err[g])
            else $error("checker active while disabled");
        AST_ERR_PIN: assert property (
            rx_edge[g] && prbs_en[g] && !ch_ctrl[g][CHC_SR] && !mute[g]
            |=> RX_NEGATIVE_DATA_OUT[g] == $past(prbs_err[g]))
            else $error("error indicator missing on negative rail");
        AST_HW_MODE: assert property (
            tx_edge[g] && !host_s && !remote[g] && fifo_valid[g]
            |=> {TX_POS_OUT[g], TX_NEG_OUT[g]} == $past(fifo_data[g]))
            else $error("pattern logic active outside host mode");
        AST_REMOTE_LOOP: assert property (
            tx_edge[g] && remote[g] |=> TX_POS_OUT[g] == $past(rpos_s[g]) && TX_NEG_OUT[g] == $past(rneg_s[g]))
            else $error("remote loop does not return recovered data");
        COV_MUTE: cover property (rx_edge[g] && mute[g]);
        COV_PRBS_ERR: cover property (prbs_en[g] && prbs_err[g]);
        COV_REMOTE: cover property (tx_edge[g] && remote[g]);
        COV_FIFO_FULL: cover property (!fifo_in_ready[g]);
    end

    // Transmit line output
    always_ff @(posedge SYS_CLK) begin
        if (SYS_RST) begin
            TX_POS_OUT <= '0;
            TX_NEG_OUT <= '0;
        end else begin
            for (int i = 0; i < NUM_CH; i++) begin
                if (tx_edge[i]) begin
                    if (remote[i]) begin
                        TX_POS_OUT[i] <= rpos_s[i];
                        TX_NEG_OUT[i] <= rneg_s[i];
                    end else if (prbs_en[i]) begin
                        TX_POS_OUT[i] <= gen_bit[i];
                        TX_NEG_OUT[i] <= 1'b0;
                    end else if (fifo_valid[i]) begin
                        TX_POS_OUT[i] <= fifo_data[i][1];
                        TX_NEG_OUT[i] <= fifo_data[i][0];
                    end else begin
                        TX_POS_OUT[i] <= 1'b0;
                        TX_NEG_OUT[i] <= 1'b0;
                    end
                end
            end
        end
    end

    // Recovered data output
    always_ff @(posedge SYS_CLK) begin
        if (SYS_RST) begin
            RX_POSITIVE_DATA_OUT <= '0;
            RX_NEGATIVE_DATA_OUT <= '0;
        end else begin
            for (int i = 0; i < NUM_CH; i++) begin
                if (rx_edge[i]) begin
                    if (mute[i]) begin
                        RX_POSITIVE_DATA_OUT[i] <= 1'b0;
                        RX_NEGATIVE_DATA_OUT[i] <= 1'b0;
                    end else begin
                        RX_POSITIVE_DATA_OUT[i] <= src_pos[i];
                        if (prbs_en[i] && !ch_ctrl[i][CHC_SR]) begin
                            RX_NEGATIVE_DATA_OUT[i] <= prbs_err[i];
                        end else if (ch_ctrl[i][CHC_SR]) begin
                            RX_NEGATIVE_DATA_OUT[i] <= lcv_s[i];
                        end else begin
                            RX_NEGATIVE_DATA_OUT[i] <= src_neg[i];
                        end
                    end
                end
            end
        end
    end

    // Analog control levels and transmit FIFO ready flag
    always_ff @(posedge SYS_CLK) begin
        if (SYS_RST) begin
            EQ_ENABLE <= '0;
            MONITOR_MODE <= '0;
            ANALOG_LOOP <= '0;
            TX_READY <= '0;
        end else begin
            for (int i = 0; i < NUM_CH; i++) begin
                EQ_ENABLE[i] <= rx_ctrl[i][RXC_EQ];
                MONITOR_MODE[i] <= rx_ctrl[i][RXC_MON];
                ANALOG_LOOP[i] <= ch_ctrl[i][CHC_LLB] & ~ch_ctrl[i][CHC_RLB];
                TX_READY[i] <= fifo_in_ready[i];
            end
        end
    end
endmodule // liu_rx_control_and_prbs_test
`default_nettype wire
